// ===== include/fpbc_pkg.sv
// Constants, types and timing for the parallel flash bus controller.
// Assumes a 50 MHz system clock and an asynchronous NOR flash on the pins.
package fpbc_pkg;

  // Register byte offsets on the control bus
  localparam logic [7:0] OFS_CMD    = 8'h00;  // Operation start and code
  localparam logic [7:0] OFS_CFG    = 8'h04;  // Width, fast and protect settings
  localparam logic [7:0] OFS_ADDR   = 8'h08;  // Target address, bit 0 is the byte bit in byte mode and word address bit 0 in word mode
  localparam logic [7:0] OFS_WDATA  = 8'h0c;  // Write data
  localparam logic [7:0] OFS_STATUS = 8'h10;  // Busy and done
  localparam logic [7:0] OFS_RDATA  = 8'h14;  // Last read data

  // Field positions
  localparam int CMD_START   = 0;  // Write one to launch
  localparam int CMD_OP_LO   = 1;  // Two-bit operation code
  localparam int CFG_BYTE    = 0;  // One selects byte width
  localparam int CFG_FAST    = 1;  // Device already in fast-program mode
  localparam int CFG_ACCEL   = 2;  // Raise high voltage during programming
  localparam int CFG_WP_HIGH = 3;  // Protect pin level when no high voltage
  localparam int ST_BUSY     = 0;
  localparam int ST_DONE     = 1;  // Sticky, write one to clear

  // Operation codes
  localparam logic [1:0] OP_READ  = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_PROG  = 2'h2;
  localparam logic [1:0] OP_RESET = 2'h3;

  // Program sequence lengths
  localparam logic [2:0] STEPS_NORMAL = 3'h4;
  localparam logic [2:0] STEPS_FAST   = 3'h2;
  localparam logic [2:0] STEPS_ONE    = 3'h1;

  // Timing in nanoseconds and derived cycle counts (least times round up)
  localparam int CLK_PERIOD_NS = 20;
  localparam int T_SETUP_NS    = 20;   // Address setup before a strobe
  localparam int T_ACCESS_NS   = 70;   // Read access from strobe
  localparam int T_WPULSE_NS   = 35;   // Write strobe width
  localparam int T_HOLD_NS     = 20;   // Data hold after the strobe rises
  localparam int T_RP_NS       = 500;  // Reset pulse width
  localparam int T_RH_NS       = 50;   // Reset high before first access
  localparam int SYNC_STAGES   = 2;    // Read data synchroniser depth
  localparam logic [7:0] SETUP_CYC  = 8'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] ACCESS_CYC = 8'((T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
  localparam logic [7:0] WPULSE_CYC = 8'((T_WPULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] HOLD_CYC   = 8'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] RP_CYC     = 8'((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] RH_CYC     = 8'((T_RH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Controller states, one-hot
  typedef enum logic [5:0] {
    S_IDLE   = 6'h01,
    S_SETUP  = 6'h02,
    S_STROBE = 6'h04,
    S_HOLD   = 6'h08,
    S_RECOV  = 6'h10,
    S_RESET  = 6'h20
  } fpbc_state_e;

endpackage : fpbc_pkg

// ===== src/fpbc_ctrl.sv
// Host-side controller that runs single bus cycles and program sequences on a parallel NOR flash.
// Assumes a classic Wishbone master on the control side and an external driver that turns the
// accelerate enable into the high programming voltage on the protect pin.
`timescale 1ns/1ps
module fpbc_ctrl #(
  parameter logic [21:0] UNLOCK1_ADDR = 22'h000001,  // Unlock cycle one, in ADDR-register form
  parameter logic [21:0] UNLOCK2_ADDR = 22'h000002,  // Unlock cycle two
  parameter logic [15:0] UNLOCK1_DATA = 16'h0001,    // Plain defaults, software must match the part
  parameter logic [15:0] UNLOCK2_DATA = 16'h0002,
  parameter logic [15:0] PROG_DATA    = 16'h0003
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Flash pins
  output logic      [20:0] addr_o,
  input  wire logic [15:0] dq_i,
  output logic      [15:0] dq_o,
  output logic      [15:0] dq_oe_n_o,
  output logic             ce_n_o,
  output logic             oe_n_o,
  output logic             we_n_o,
  output logic             reset_n_o,
  output logic             byte_n_o,
  output logic             wp_level_o,
  output logic             accel_hv_o
);

  logic             rst_m, rst_n;          // Reset release synchroniser
  logic [15:0]      dq_m, dq_s;            // Data input synchroniser
  fpbc_pkg::fpbc_state_e state;            // Cycle sequencer
  logic [7:0]       cnt;                   // Cycles spent in the current state
  logic [2:0]       step;                  // Index within a program sequence
  logic [2:0]       nsteps;                // Bus cycles in this operation
  logic [1:0]       op;                    // Operation in progress
  logic             start_req;             // Launch pulse from the bus side
  logic             fin;                   // Completion pulse to the bus side
  logic             done;                  // Sticky completion flag
  logic             fast;                  // Latched fast-program choice
  logic             byte_mode, cfg_fast, cfg_accel, cfg_wp;
  logic [1:0]       req_op;
  logic [21:0]      addr_r;
  logic [15:0]      wdata, rdata;
  logic [21:0]      cur_a;                 // Address of the current step
  logic [15:0]      cur_d;                 // Data of the current step
  logic             busy;
  logic             wr_hit, rd_hit;

  // Merge a write into a register honouring byte lanes
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction : lane_merge

  // Address of sequence step; fast sequences skip the two unlock cycles
  function automatic logic [21:0] step_addr(input logic [2:0] s, input logic f, input logic [1:0] o,
                                            input logic [21:0] tgt);
    logic [2:0] k;
    k = (f || o != fpbc_pkg::OP_PROG) ? s + 3'h2 : s;
    if (o != fpbc_pkg::OP_PROG)
      k = 3'h3;
    unique case (k)
      3'h0:    return UNLOCK1_ADDR;
      3'h1:    return UNLOCK2_ADDR;
      3'h2:    return UNLOCK1_ADDR;
      default: return tgt;
    endcase
  endfunction : step_addr

  // Data of sequence step
  function automatic logic [15:0] step_data(input logic [2:0] s, input logic f, input logic [1:0] o,
                                            input logic [15:0] d);
    logic [2:0] k;
    k = f ? s + 3'h2 : s;
    if (o != fpbc_pkg::OP_PROG)
      k = 3'h3;
    unique case (k)
      3'h0:    return UNLOCK1_DATA;
      3'h1:    return UNLOCK2_DATA;
      3'h2:    return PROG_DATA;
      default: return d;
    endcase
  endfunction : step_data

  assign busy   = (state != fpbc_pkg::S_IDLE) || start_req;
  assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign rd_hit = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  // Unlock and command steps go to the unlock addresses, the final step to the target address
  // Single writes let software build erase sequences for one sector, several or all
  assign cur_a  = step_addr(step, fast, op, addr_r);
  assign cur_d  = step_data(step, fast, op, wdata);

  // Reset release through two flip-flops
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  // Data pins come from another timing domain, so two flops before use
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dq_m <= 16'h0000;
      dq_s <= 16'h0000;
    end
    else
    begin
      dq_m <= dq_i;
      dq_s <= dq_m;
    end
  end

  // Bus slave: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  // Read mux; unmapped offsets read zero
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      wb_dat_o <= 32'h00000000;
    else if (rd_hit)
    begin
      unique case (wb_adr_i)
        fpbc_pkg::OFS_CMD:    wb_dat_o <= {29'h0, req_op, 1'b0};
        fpbc_pkg::OFS_CFG:    wb_dat_o <= {28'h0, cfg_wp, cfg_accel, cfg_fast, byte_mode};
        fpbc_pkg::OFS_ADDR:   wb_dat_o <= {10'h0, addr_r};
        fpbc_pkg::OFS_WDATA:  wb_dat_o <= {16'h0, wdata};
        fpbc_pkg::OFS_STATUS: wb_dat_o <= {30'h0, done, busy};
        fpbc_pkg::OFS_RDATA:  wb_dat_o <= {16'h0, rdata};
        default:              wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  // Software registers; settings are frozen while an operation runs so pins never change mid-cycle
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      byte_mode <= 1'b0;
      cfg_fast  <= 1'b0;
      cfg_accel <= 1'b0;
      cfg_wp    <= 1'b0;
      addr_r    <= 22'h000000;
      wdata     <= 16'h0000;
      req_op    <= fpbc_pkg::OP_READ;
      start_req <= 1'b0;
    end
    else
    begin
      start_req <= 1'b0;
      if (wr_hit && !busy)
      begin
        unique case (wb_adr_i)
          fpbc_pkg::OFS_CMD:
          begin
            if (wb_sel_i[0])
            begin
              req_op    <= wb_dat_i[fpbc_pkg::CMD_OP_LO +: 2];
              start_req <= wb_dat_i[fpbc_pkg::CMD_START];
            end
          end
          fpbc_pkg::OFS_CFG:
          begin
            if (wb_sel_i[0])
            begin
              byte_mode <= wb_dat_i[fpbc_pkg::CFG_BYTE];
              cfg_fast  <= wb_dat_i[fpbc_pkg::CFG_FAST];
              cfg_accel <= wb_dat_i[fpbc_pkg::CFG_ACCEL];
              cfg_wp    <= wb_dat_i[fpbc_pkg::CFG_WP_HIGH];
            end
          end
          fpbc_pkg::OFS_ADDR:  addr_r <= 22'(lane_merge({10'h0, addr_r}, wb_dat_i, wb_sel_i));
          fpbc_pkg::OFS_WDATA: wdata  <= 16'(lane_merge({16'h0, wdata}, wb_dat_i, wb_sel_i));
          default:
          begin
          end
        endcase
      end
    end
  end

  // Done flag: a completion in the clearing cycle wins
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      done <= 1'b0;
    else
      done <= fin || (done && !(wr_hit && wb_adr_i == fpbc_pkg::OFS_STATUS && wb_sel_i[0]
                                && wb_dat_i[fpbc_pkg::ST_DONE]));
  end

  // Static pin levels: width select and protect level are always driven, never left floating
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      byte_n_o   <= 1'b1;
      wp_level_o <= 1'b0;
    end
    else
    begin
      byte_n_o   <= !byte_mode;
      wp_level_o <= cfg_wp;
    end
  end

  // Cycle sequencer and all strobe, address and data pins
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state      <= fpbc_pkg::S_IDLE;
      cnt        <= 8'h00;
      step       <= 3'h0;
      nsteps     <= fpbc_pkg::STEPS_ONE;
      op         <= fpbc_pkg::OP_READ;
      fast       <= 1'b0;
      fin        <= 1'b0;
      rdata      <= 16'h0000;
      addr_o     <= 21'h000000;
      dq_o       <= 16'h0000;
      dq_oe_n_o  <= 16'hffff;
      ce_n_o     <= 1'b1;
      oe_n_o     <= 1'b1;
      we_n_o     <= 1'b1;
      reset_n_o  <= 1'b1;
      accel_hv_o <= 1'b0;
    end
    else
    begin
      fin <= 1'b0;
      cnt <= cnt + 8'h01;
      unique case (state)
        fpbc_pkg::S_IDLE:
        begin
          // Standby: nothing selected, data pins released
          ce_n_o    <= 1'b1;
          oe_n_o    <= 1'b1;
          we_n_o    <= 1'b1;
          dq_oe_n_o <= 16'hffff;
          if (start_req)
          begin
            op   <= req_op;
            fast <= cfg_fast || cfg_accel;
            step <= 3'h0;
            cnt  <= 8'h00;
            // Program runs four cycles, or two once fast mode or accelerate is on
            nsteps <= (req_op != fpbc_pkg::OP_PROG) ? fpbc_pkg::STEPS_ONE :
                      (cfg_fast || cfg_accel) ? fpbc_pkg::STEPS_FAST : fpbc_pkg::STEPS_NORMAL;
            // High voltage only for programming cycles
            accel_hv_o <= cfg_accel && (req_op == fpbc_pkg::OP_PROG);
            if (req_op == fpbc_pkg::OP_RESET)
            begin
              reset_n_o <= 1'b0;
              state     <= fpbc_pkg::S_RESET;
            end
            else
              state <= fpbc_pkg::S_SETUP;
          end
        end
        fpbc_pkg::S_SETUP:
        begin
          // Address first; in byte mode bit 15 carries the byte address bit
          ce_n_o <= 1'b0;
          addr_o <= byte_mode ? cur_a[21:1] : cur_a[20:0];  // Bank and sector bits pass whole
          dq_o   <= byte_mode ? {cur_a[0], 7'h00, cur_d[7:0]} : cur_d;
          if (op == fpbc_pkg::OP_READ)
            dq_oe_n_o <= byte_mode ? 16'h7fff : 16'hffff;
          else
            dq_oe_n_o <= byte_mode ? 16'h7f00 : 16'h0000;
          // Strobe only after a full setup cycle, so the flash latches a settled address
          if (cnt == fpbc_pkg::SETUP_CYC)
          begin
            cnt   <= 8'h00;
            state <= fpbc_pkg::S_STROBE;
            if (op == fpbc_pkg::OP_READ)
              oe_n_o <= 1'b0;
            else
              we_n_o <= 1'b0;
          end
        end
        fpbc_pkg::S_STROBE:
        begin
          // Reads need no prior command after reset
          if (op == fpbc_pkg::OP_READ && cnt == fpbc_pkg::ACCESS_CYC - 8'h01)
          begin
            rdata  <= byte_mode ? {8'h00, dq_s[7:0]} : dq_s;
            oe_n_o <= 1'b1;
            cnt    <= 8'h00;
            state  <= fpbc_pkg::S_HOLD;
          end
          else if (op != fpbc_pkg::OP_READ && cnt == fpbc_pkg::WPULSE_CYC - 8'h01)
          begin
            we_n_o <= 1'b1;  // Rise first, data held after
            cnt    <= 8'h00;
            state  <= fpbc_pkg::S_HOLD;
          end
        end
        fpbc_pkg::S_HOLD:
        begin
          if (cnt == fpbc_pkg::HOLD_CYC - 8'h01)
          begin
            ce_n_o    <= 1'b1;
            dq_oe_n_o <= 16'hffff;
            cnt       <= 8'h00;
            state     <= fpbc_pkg::S_RECOV;
          end
        end
        fpbc_pkg::S_RECOV:
        begin
          // Deselected here and through the first setup cycle, two cycles between bus cycles
          cnt <= 8'h00;
          if (step + 3'h1 == nsteps)
          begin
            fin        <= 1'b1;
            accel_hv_o <= 1'b0;
            state      <= fpbc_pkg::S_IDLE;
          end
          else
          begin
            step  <= step + 3'h1;
            state <= fpbc_pkg::S_SETUP;
          end
        end
        fpbc_pkg::S_RESET:
        begin
          // Hold reset, then wait before any access
          if (!reset_n_o && cnt == fpbc_pkg::RP_CYC - 8'h01)
          begin
            reset_n_o <= 1'b1;
            cnt       <= 8'h00;
          end
          else if (reset_n_o && cnt == fpbc_pkg::RH_CYC - 8'h01)
          begin
            fin   <= 1'b1;
            state <= fpbc_pkg::S_IDLE;
          end
        end
        default: state <= fpbc_pkg::S_IDLE;
      endcase
    end
  end

  // Helper: write strobes seen in the current operation
  logic [2:0] we_seen;
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      we_seen <= 3'h0;
    else if (state == fpbc_pkg::S_IDLE)
      we_seen <= 3'h0;
    else if (state == fpbc_pkg::S_SETUP && cnt == fpbc_pkg::SETUP_CYC && op != fpbc_pkg::OP_READ)
      we_seen <= we_seen + 3'h1;
  end

  property p_read_levels;
    @(posedge clk_i) disable iff (!rst_n) !oe_n_o |-> (!ce_n_o && we_n_o && (&dq_oe_n_o[14:0]));
  endproperty
  a_read_levels: assert property (p_read_levels) else $error("read strobe with bad levels");

  property p_write_levels;
    @(posedge clk_i) disable iff (!rst_n) !we_n_o |-> (!ce_n_o && oe_n_o);
  endproperty
  a_write_levels: assert property (p_write_levels) else $error("write strobe with bad levels");

  property p_byte_float;
    @(posedge clk_i) disable iff (!rst_n) (!byte_n_o && !ce_n_o) |-> (&dq_oe_n_o[14:8]) && !dq_oe_n_o[15];
  endproperty
  a_byte_float: assert property (p_byte_float) else $error("byte mode drives upper data");

  property p_word_drive;
    @(posedge clk_i) disable iff (!rst_n) (byte_n_o && !we_n_o) |-> (dq_oe_n_o == 16'h0000);
  endproperty
  a_word_drive: assert property (p_word_drive) else $error("word write not on all pins");

  property p_byte_addr;
    @(posedge clk_i) disable iff (!rst_n) (!byte_n_o && !ce_n_o) |-> (dq_o[15] == cur_a[0]);
  endproperty
  a_byte_addr: assert property (p_byte_addr) else $error("byte address bit wrong");

  property p_write_hold;
    @(posedge clk_i) disable iff (!rst_n) $rose(we_n_o) |-> ($stable(addr_o) && $stable(dq_o) && !ce_n_o);
  endproperty
  a_write_hold: assert property (p_write_hold) else $error("write data not held past strobe");

  property p_accel_only_prog;
    @(posedge clk_i) disable iff (!rst_n) accel_hv_o |-> (op == fpbc_pkg::OP_PROG && state != fpbc_pkg::S_IDLE);
  endproperty
  a_accel_only_prog: assert property (p_accel_only_prog) else $error("high voltage outside program");

  property p_reset_quiet;
    @(posedge clk_i) disable iff (!rst_n) $fell(reset_n_o) |-> (ce_n_o && reset_n_o == 1'b0) [*8];
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("access during reset pulse");

  property p_prog_count;
    @(posedge clk_i) disable iff (!rst_n) (fin && op == fpbc_pkg::OP_PROG) |->
      (we_seen == (fast ? fpbc_pkg::STEPS_FAST : fpbc_pkg::STEPS_NORMAL));
  endproperty
  a_prog_count: assert property (p_prog_count) else $error("wrong number of program cycles");

  property p_standby;
    @(posedge clk_i) disable iff (!rst_n) fin |=> (ce_n_o && oe_n_o && we_n_o && (&dq_oe_n_o));
  endproperty
  a_standby: assert property (p_standby) else $error("not in standby after operation");

endmodule : fpbc_ctrl

// ===== testbench/fpbc_flash_model.sv
// Behavioural flash device on the controller's pins.
// Assumes the bench resolves the data wires from both enables.
`timescale 1ns/1ps
module fpbc_flash_model #(
  parameter int          DLY  = 60,         // Slow answer, inside 70 ns
  parameter logic [21:0] UA1  = 22'h000001, // Unlock addresses
  parameter logic [21:0] UA2  = 22'h000002,
  parameter logic [15:0] UD1  = 16'h0001,   // Command codes
  parameter logic [15:0] UD2  = 16'h0002,
  parameter logic [15:0] PRG  = 16'h0003,
  parameter logic [15:0] AUTO = 16'h0004,
  parameter logic [15:0] ID   = 16'h005a,   // Arbitrary value
  parameter logic        LOCK = 1'b0        // Last action on outer boots
) (
  // Pins
  input  wire logic [20:0] addr_i,
  input  wire logic [15:0] dq_i,
  input  wire logic [15:0] dq_oe_n_i,
  input  wire logic        ce_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        we_n_i,
  input  wire logic        reset_n_i,
  input  wire logic        byte_n_i,
  input  wire logic        wp_i,
  input  wire logic        hv_i,
  // Answer
  output logic      [15:0] fl_dq_o,
  output logic      [15:0] fl_en_o,
  output int               n_wr_o,
  output int               viol_o
);
  logic [15:0] mem [logic [21:0]];  // Unwritten cells read erased
  logic [21:0] key;
  logic [15:0] d, rd;
  logic [1:0]  seq = 0;             // Unlock progress, checked against the unlock addresses
  logic        prg = 0;
  logic        auto = 0;
  wire  [21:0] rkey = byte_n_i ? {1'b0, addr_i} : {addr_i, dq_i[15]};
  wire         wr = !we_n_i && !ce_n_i && reset_n_i;
  wire         on = !ce_n_i && !oe_n_i && we_n_i && reset_n_i;
  initial n_wr_o = 0;
  initial viol_o = 0;
  // Back to array read
  always @(negedge reset_n_i)
  begin
    seq = 0;
    prg = 0;
    auto = 0;
  end
  // Address on the later fall; upper lines must float in byte mode
  always @(posedge wr)
  begin
    key = rkey;
    if (!oe_n_i || (!byte_n_i && dq_oe_n_i[14:8] !== 7'h7f))
      viol_o++;
  end
  // A read with write low, or under high voltage, is misuse
  always @(negedge oe_n_i)
    if (!we_n_i || hv_i)
      viol_o++;
  // Data on the earlier rise, then one command step
  always @(negedge wr)
  begin
    d = byte_n_i ? dq_i : {8'h00, dq_i[7:0]};
    n_wr_o++;
    if (prg && (hv_i || (wp_i && !LOCK) || addr_i[20:15] != 6'h3f))
      mem[key] = (mem.exists(key) ? mem[key] : 16'hffff) & d;
    if (prg)
      prg = 0;
    else if (hv_i && d == PRG)
      prg = 1;
    else if (seq == 0 && key == UA1 && d == UD1)
      seq = 1;
    else if (seq == 1 && key == UA2 && d == UD2)
      seq = 2;
    else
    begin
      if (hv_i)
        viol_o++;
      prg = seq == 2 && key == UA1 && d == PRG;
      auto = auto || (seq == 2 && key == UA1 && d == AUTO);  // Held till reset
      seq = 0;
    end
  end
  always @(rkey or auto or n_wr_o)
    rd = auto ? ID : (mem.exists(rkey) ? mem[rkey] : 16'hffff);
  // Low byte only in byte mode
  assign #(DLY) fl_en_o = !on ? 16'h0000 : byte_n_i ? 16'hffff : 16'h00ff;
  assign #(DLY) fl_dq_o = byte_n_i ? rd : {8'h00, rd[7:0]};
endmodule : fpbc_flash_model

// ===== testbench/parallel_flash_bus_operations_test.sv
// Bench: controller on a behavioural flash, driven over Wishbone.
// Assumes the model answers inside the read window.
`timescale 1ns/1ps
module parallel_flash_bus_operations_test;
  localparam logic [21:0] UA1 = 22'h000123;
  localparam logic [21:0] UA2 = 22'h000246;
  localparam logic [15:0] UD1 = 16'h0011;
  localparam logic [15:0] UD2 = 16'h0022;
  localparam logic [15:0] PRG = 16'h0033;
  localparam logic [15:0] AUT = 16'h0044;
  localparam logic [15:0] ID  = 16'h005a;  // Arbitrary value
  logic        clk_i = 0, rst_n_i = 0, cyc = 0, stb = 0, we = 0, flt = 0;
  logic [7:0]  adr = 0;
  logic [31:0] wdat = 0, wb_dat_o, q_exp[$], q_msk[$];
  logic        wb_ack_o, ce_n_o, oe_n_o, we_n_o, reset_n_o, byte_n_o, wp_level_o, accel_hv_o;
  logic [20:0] addr_o;
  logic [15:0] dq_o, dq_oe_n_o, fl_dq, fl_en;
  // Released lines show a pattern that changes every cycle
  wire  [15:0] dq_w = (~dq_oe_n_o & dq_o) | (dq_oe_n_o & fl_en & fl_dq) | (dq_oe_n_o & ~fl_en & {16{flt}});
  int          err_total = 0, n_checks = 0, n_wr, viol;
  integer      seed = 32'h30d7fd52;
  logic [3:0]  cfgs [7] = '{4'h1, 4'h5, 4'h8, 4'h4, 4'h0, 4'h8, 4'h4};
  logic        prot [7] = '{0, 0, 0, 0, 1, 1, 1};
  logic        keep [7] = '{1, 1, 1, 1, 0, 1, 1};
  int          nws  [7] = '{4, 2, 4, 2, 4, 4, 2};
  fpbc_ctrl #(.UNLOCK1_ADDR(UA1), .UNLOCK2_ADDR(UA2), .UNLOCK1_DATA(UD1), .UNLOCK2_DATA(UD2),
    .PROG_DATA(PRG)) dut (.clk_i, .rst_n_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o, .wb_ack_o, .addr_o, .dq_i(dq_w), .dq_o, .dq_oe_n_o,
    .ce_n_o, .oe_n_o, .we_n_o, .reset_n_o, .byte_n_o, .wp_level_o, .accel_hv_o);
  fpbc_flash_model #(.UA1(UA1), .UA2(UA2), .UD1(UD1), .UD2(UD2), .PRG(PRG), .AUTO(AUT), .ID(ID)) flash (
    .addr_i(addr_o), .dq_i(dq_w), .dq_oe_n_i(dq_oe_n_o), .ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o),
    .reset_n_i(reset_n_o), .byte_n_i(byte_n_o), .wp_i(wp_level_o), .hv_i(accel_hv_o), .fl_dq_o(fl_dq),
    .fl_en_o(fl_en), .n_wr_o(n_wr), .viol_o(viol));
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) flt <= ~flt;
  task automatic wrap_up;
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  task automatic stuck;
    err_total++;
    wrap_up();
  endtask : stuck
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One classic cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    i = 0;
    do
    begin
      @(posedge clk_i);
      i++;
    end
    while (wb_ack_o !== 1'b1 && i < 20);
    if (wb_ack_o !== 1'b1)
      stuck();
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  // Read with a noted expectation; a zero mask marks a poll
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
    logic [31:0] q;
    q_exp.push_back(e);
    q_msk.push_back(m);
    wb(1'b0, a, 32'h0, q);
  endtask : rd
  // Launch one flash operation and wait for done, then clear it
  task automatic xfer(input logic [1:0] op, input logic [21:0] a, input logic [15:0] d);
    logic [31:0] q;
    wb(1'b1, fpbc_pkg::OFS_ADDR, {10'h0, a}, q);
    wb(1'b1, fpbc_pkg::OFS_WDATA, {16'h0, d}, q);
    wb(1'b1, fpbc_pkg::OFS_CMD, {29'h0, op, 1'b1}, q);
    for (int i = 0; i <= 100; i++)
    begin
      if (i == 100)
        stuck();
      rd(fpbc_pkg::OFS_STATUS, 32'h0, 32'h0);
      if (wb_dat_o[fpbc_pkg::ST_DONE] === 1'b1)
        break;
    end
    wb(1'b1, fpbc_pkg::OFS_STATUS, 32'h2, q);
  endtask : xfer
  // Compare each read answer with the oldest note
  always @(posedge clk_i)
    if (cyc && stb && !we && wb_ack_o === 1'b1 && q_exp.size() > 0)
    begin
      if (q_msk[0] != 32'h0)
        check(wb_dat_o & q_msk[0], q_exp[0]);
      void'(q_exp.pop_front());
      void'(q_msk.pop_front());
    end
  initial
  begin
    logic [21:0] a;
    logic [15:0] d, e;
    logic [31:0] q;
    int          n0;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(fpbc_pkg::OFS_CFG, 32'h0);
    rd(8'h1c, 32'h0);
    a = 22'(15'($random(seed)));
    xfer(fpbc_pkg::OP_READ, a, 16'h0);
    rd(fpbc_pkg::OFS_RDATA, 32'hffff);
    // Byte, word, fast and protected programs, each read back
    for (int k = 0; k < 7; k++)
    begin
      wb(1'b1, fpbc_pkg::OFS_CFG, {28'h0, cfgs[k]}, q);
      a = {1'b0, prot[k] ? 6'h3f : 6'h00, 15'($random(seed))};
      d = 16'($random(seed));
      e = cfgs[k][0] ? {8'h00, keep[k] ? d[7:0] : 8'hff} : keep[k] ? d : 16'hffff;
      n0 = n_wr;
      xfer(fpbc_pkg::OP_PROG, a, d);
      check(32'(n_wr - n0), 32'(nws[k]));
      check({31'h0, accel_hv_o}, 32'h0);
      xfer(fpbc_pkg::OP_READ, a, 16'h0);
      rd(fpbc_pkg::OFS_RDATA, {16'h0, e});
    end
    rd(fpbc_pkg::OFS_CMD, 32'h0);
    wb(1'b1, fpbc_pkg::OFS_CFG, 32'h0, q);
    xfer(fpbc_pkg::OP_WRITE, UA1, UD1);
    xfer(fpbc_pkg::OP_WRITE, UA2, UD2);
    xfer(fpbc_pkg::OP_WRITE, UA1, AUT);
    xfer(fpbc_pkg::OP_READ, a, 16'h0);
    rd(fpbc_pkg::OFS_RDATA, {16'h0, ID});
    xfer(fpbc_pkg::OP_RESET, a, 16'h0);
    xfer(fpbc_pkg::OP_READ, a, 16'h0);
    rd(fpbc_pkg::OFS_RDATA, {16'h0, e});
    check(32'(viol), 32'h0);
    wrap_up();
  end
endmodule : parallel_flash_bus_operations_test
